// [hdl/slpm_pkg.sv]
/*
 * Shared constants and types of the serial line power manager.
 * Assumes a single 50 MHz clock feeding every user of this package.
 */
package slpm_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int     SLPM_CLK_HZ         = 50_000_000;
    localparam int     SLPM_CLK_PERIOD_NS  = 20;
    localparam int     SLPM_INACT_TIME_S   = 30;
    localparam longint SLPM_INACT_CYCLES_L = longint'(SLPM_INACT_TIME_S) * longint'(SLPM_CLK_HZ);
    localparam int     SLPM_IDLE_W         = 31;
    localparam logic [SLPM_IDLE_W-1:0] SLPM_INACT_CYCLES = SLPM_IDLE_W'(SLPM_INACT_CYCLES_L);
    localparam int     SLPM_ABSENT_TIME_NS = 30_000;
    localparam int     SLPM_ABSENT_CYCLES  = (SLPM_ABSENT_TIME_NS + SLPM_CLK_PERIOD_NS - 1) / SLPM_CLK_PERIOD_NS;
    localparam int     SLPM_DWELL_W        = 11;
    localparam int     SLPM_LINE_RATE_BPS  = 460_000;
    localparam int     SLPM_BIT_CYCLES     = (SLPM_CLK_HZ + SLPM_LINE_RATE_BPS - 1) / SLPM_LINE_RATE_BPS;
    localparam int     SLPM_BIT_W          = 7;

    // ------------------------------------------------------------
    // Structure and reset values
    // ------------------------------------------------------------
    localparam int   SLPM_CHANNELS      = 2;
    localparam int   SLPM_FIFO_DEPTH    = 8;
    localparam logic SLPM_ABSENT_N_RST  = 1'h0;
    localparam logic [SLPM_CHANNELS-1:0] SLPM_DRV_OUT_RST = 2'h3;
    localparam logic [SLPM_CHANNELS-1:0] SLPM_RX_OUT_RST  = 2'h3;

    typedef enum logic [1:0]
    {
        SLPM_ST_DOWN    = 2'b00,
        SLPM_ST_PUMP_UP = 2'b01,
        SLPM_ST_RUN     = 2'b10
    } slpm_state_type;

    // Everything that arrives from outside the clock domain
    typedef struct packed
    {
        logic                     keep_awake;
        logic                     shutdown_n;
        logic                     pump_reg;
        logic [SLPM_CHANNELS-1:0] rx_lvl;
        logic [SLPM_CHANNELS-1:0] rx_valid;
        logic [SLPM_CHANNELS-1:0] rx_quiet;
    } slpm_pins_type;

endpackage

// [hdl/slpm_manager.sv]
/*
 * Power manager of a dual driver, dual receiver serial line transceiver,
 * with the FIFO that feeds the drivers.
 * Assumes analog comparators outside report line polarity, valid level,
 * quiet band and charge pump regulation as asynchronous logic levels.
 */
`timescale 1ns/1ps

module slpm_fifo
    import slpm_pkg::*;
#(
    parameter int WIDTH = SLPM_CHANNELS,
    parameter int DEPTH = SLPM_FIFO_DEPTH
)
(
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire logic             CE,
    input  wire logic             IN_VALID,
    output logic                  IN_READY,
    input  wire logic [WIDTH-1:0] IN_DATA,
    output logic                  OUT_VALID,
    input  wire logic             OUT_READY,
    output logic      [WIDTH-1:0] OUT_DATA
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
    begin : g_bad_shape
        $error("slpm_fifo needs a power of two depth of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign IN_READY  = (count != (AW+1)'(DEPTH));
    assign OUT_VALID = (count != '0);
    assign OUT_DATA  = mem[rd_ptr];

    always_comb
    begin
        push        = IN_VALID && IN_READY && CE;
        pop         = OUT_VALID && OUT_READY && CE;
        next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage carries no reset; only the pointers and count decide what is valid
    always_ff @(posedge CLK)
    begin
        if (push)
        begin
            mem[wr_ptr] <= IN_DATA;
        end
    end
endmodule // slpm_fifo

module slpm_manager
    import slpm_pkg::*;
#(
    parameter logic [SLPM_IDLE_W-1:0] INACT_CYCLES = SLPM_INACT_CYCLES
)
(
    input  wire logic                     CLK,
    input  wire logic                     RESET_N,
    input  wire logic                     CE,
    input  wire logic                     KEEP_AWAKE_IN,
    input  wire logic                     SHUTDOWN_N_IN,
    input  wire logic                     PUMP_REGULATED,
    input  wire logic [SLPM_CHANNELS-1:0] RX_LINE_IN,
    input  wire logic [SLPM_CHANNELS-1:0] RX_LINE_VALID,
    input  wire logic [SLPM_CHANNELS-1:0] RX_LINE_QUIET,
    input  wire logic                     TX_VALID,
    output logic                          TX_READY,
    input  wire logic [SLPM_CHANNELS-1:0] TX_DATA,
    output logic                          PUMP_EN,
    output logic                          READY,
    output logic      [SLPM_CHANNELS-1:0] DRV_OUT,
    output logic      [SLPM_CHANNELS-1:0] DRV_OE,
    output logic      [SLPM_CHANNELS-1:0] RX_LOGIC_OUT,
    output logic                          SIG_ABSENT_N
);
    if (INACT_CYCLES < SLPM_IDLE_W'(2))
    begin : g_bad_timer
        $error("slpm_manager needs an inactivity count of at least 2");
    end

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    slpm_pins_type pins_raw;
    slpm_pins_type sync1;
    slpm_pins_type sync2;
    slpm_pins_type sync3;
    slpm_pins_type clean;
    slpm_pins_type next_clean;

    assign pins_raw = '{keep_awake: KEEP_AWAKE_IN, shutdown_n: SHUTDOWN_N_IN, pump_reg: PUMP_REGULATED,
                        rx_lvl: RX_LINE_IN, rx_valid: RX_LINE_VALID, rx_quiet: RX_LINE_QUIET};

    // A bit only moves once the last two stages agree, which drops one-cycle glitches
    always_comb
    begin
        next_clean = (sync2 ~^ sync3) & sync3 | (sync2 ^ sync3) & clean;
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            clean <= '0;
        end
        else if (CE)
        begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            clean <= next_clean;
        end
    end

    // ------------------------------------------------------------
    // Activity detection and receive path
    // ------------------------------------------------------------
    logic [SLPM_CHANNELS-1:0] prev_lvl;
    logic [SLPM_CHANNELS-1:0] prev_valid;
    logic [SLPM_CHANNELS-1:0] rx_out;
    logic [SLPM_CHANNELS-1:0] next_rx_out;
    logic                     rx_edge;
    logic                     activity;
    logic                     fifo_in_ready;
    logic                     fifo_out_valid;
    logic [SLPM_CHANNELS-1:0] fifo_out_data;
    slpm_state_type           state;

    always_comb
    begin
        rx_edge     = |((clean.rx_lvl ^ prev_lvl) | (clean.rx_valid & ~prev_valid));
        next_rx_out = ~clean.rx_lvl;
        // Host words and a backlog seen while asleep count as receiver edges
        activity    = rx_edge || (TX_VALID && fifo_in_ready)
                      || (fifo_out_valid && state == SLPM_ST_DOWN);
    end

    // The receive register ignores power state on purpose
    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            prev_lvl   <= '0;
            prev_valid <= '0;
            rx_out     <= SLPM_RX_OUT_RST;
        end
        else if (CE)
        begin
            prev_lvl   <= clean.rx_lvl;
            prev_valid <= clean.rx_valid;
            rx_out     <= next_rx_out;
        end
    end

    assign RX_LOGIC_OUT = rx_out;

    // ------------------------------------------------------------
    // Signal presence detector
    // ------------------------------------------------------------
    logic                    absent_n;
    logic                    next_absent_n;
    logic [SLPM_DWELL_W-1:0] dwell;
    logic [SLPM_DWELL_W-1:0] next_dwell;

    // Runs independent of power state so the host may feed it to the force pins
    always_comb
    begin
        next_absent_n = absent_n;
        next_dwell    = dwell;
        if (|clean.rx_valid)
        begin
            next_absent_n = 1'h1;
            next_dwell    = '0;
        end
        else if (&clean.rx_quiet)
        begin
            if (dwell == SLPM_DWELL_W'(SLPM_ABSENT_CYCLES))
            begin
                next_absent_n = 1'h0;
            end
            else
            begin
                next_dwell = dwell + SLPM_DWELL_W'(1);
            end
        end
        else
        begin
            next_dwell = '0;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            absent_n <= SLPM_ABSENT_N_RST;
            dwell    <= '0;
        end
        else if (CE)
        begin
            absent_n <= next_absent_n;
            dwell    <= next_dwell;
        end
    end

    assign SIG_ABSENT_N = absent_n;

    // ------------------------------------------------------------
    // Power state machine and inactivity timer
    // ------------------------------------------------------------
    logic                   auto_en;
    logic                   forced_on;
    slpm_state_type         next_state;
    logic [SLPM_IDLE_W-1:0] idle;
    logic [SLPM_IDLE_W-1:0] next_idle;
    logic                   expired;

    always_comb
    begin
        auto_en   = !clean.keep_awake && clean.shutdown_n;
        forced_on = clean.keep_awake && clean.shutdown_n;
        expired   = auto_en && !activity && idle == INACT_CYCLES - SLPM_IDLE_W'(1);
        next_idle = (activity || !auto_en || state == SLPM_ST_DOWN) ? '0 : idle + SLPM_IDLE_W'(1);
        next_state = state;
        case (state)
            SLPM_ST_DOWN:
            begin
                if (forced_on || (auto_en && activity))
                begin
                    next_state = SLPM_ST_PUMP_UP;
                end
            end
            SLPM_ST_PUMP_UP:
            begin
                if (clean.pump_reg)
                begin
                    next_state = SLPM_ST_RUN;
                end
            end
            SLPM_ST_RUN:
            begin
                if (!clean.pump_reg)
                begin
                    next_state = SLPM_ST_PUMP_UP;
                end
                else if (expired)
                begin
                    next_state = SLPM_ST_DOWN;
                end
            end
            default:
            begin
                next_state = SLPM_ST_DOWN;
            end
        endcase
        if (!clean.shutdown_n)
        begin
            next_state = SLPM_ST_DOWN;
        end
        else if (expired && state == SLPM_ST_PUMP_UP)
        begin
            next_state = SLPM_ST_DOWN;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state <= SLPM_ST_DOWN;
            idle  <= '0;
        end
        else if (CE)
        begin
            state <= next_state;
            idle  <= next_idle;
        end
    end

    assign PUMP_EN = (state != SLPM_ST_DOWN);
    assign READY   = (state == SLPM_ST_RUN);
    assign DRV_OE  = {SLPM_CHANNELS{state == SLPM_ST_RUN}};

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic [SLPM_CHANNELS-1:0] drv;
    logic [SLPM_CHANNELS-1:0] next_drv;
    logic [SLPM_BIT_W-1:0]    bit_cnt;
    logic [SLPM_BIT_W-1:0]    next_bit_cnt;
    logic                     pop;

    // Words only leave while ready, so an asleep device back-pressures the host
    slpm_fifo #(.WIDTH(SLPM_CHANNELS), .DEPTH(SLPM_FIFO_DEPTH)) u_fifo
    (
        .CLK       (CLK),
        .RESET_N   (RESET_N),
        .CE        (CE),
        .IN_VALID  (TX_VALID),
        .IN_READY  (fifo_in_ready),
        .IN_DATA   (TX_DATA),
        .OUT_VALID (fifo_out_valid),
        .OUT_READY (pop),
        .OUT_DATA  (fifo_out_data)
    );

    assign TX_READY = fifo_in_ready;

    always_comb
    begin
        pop          = fifo_out_valid && state == SLPM_ST_RUN && bit_cnt == '0;
        next_drv     = pop ? ~fifo_out_data : drv;
        next_bit_cnt = pop ? SLPM_BIT_W'(SLPM_BIT_CYCLES - 1)
                           : (bit_cnt != '0 ? bit_cnt - SLPM_BIT_W'(1) : bit_cnt);
    end

    always_ff @(posedge CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            drv     <= SLPM_DRV_OUT_RST;
            bit_cnt <= '0;
        end
        else if (CE)
        begin
            drv     <= next_drv;
            bit_cnt <= next_bit_cnt;
        end
    end

    assign DRV_OUT = drv;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    localparam int ABSENT_MIN = SLPM_ABSENT_CYCLES;

    property p_auto_gate;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && state == SLPM_ST_RUN && clean.pump_reg && !auto_en && clean.shutdown_n) |=> state == SLPM_ST_RUN;
    endproperty
    a_auto_gate: assert property (p_auto_gate) else $error("Forced-on device left run");

    property p_timeout;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && state == SLPM_ST_RUN && clean.pump_reg && expired) |=> state == SLPM_ST_DOWN && !READY;
    endproperty
    a_timeout: assert property (p_timeout) else $error("No power-down after idle time");

    property p_wake;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && state == SLPM_ST_DOWN && auto_en && activity) |=> state == SLPM_ST_PUMP_UP && PUMP_EN;
    endproperty
    a_wake: assert property (p_wake) else $error("Edge did not wake the device");

    property p_valid_level;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && |clean.rx_valid) |=> SIG_ABSENT_N;
    endproperty
    a_valid_level: assert property (p_valid_level) else $error("Signal output low with valid level");

    property p_quiet_dwell;
        @(posedge CLK) disable iff (!RESET_N)
        $fell(SIG_ABSENT_N) |-> $past(dwell) == SLPM_DWELL_W'(ABSENT_MIN);
    endproperty
    a_quiet_dwell: assert property (p_quiet_dwell) else $error("Signal output fell too early");

    property p_rx_follow;
        @(posedge CLK) disable iff (!RESET_N)
        CE |=> RX_LOGIC_OUT == ~$past(clean.rx_lvl);
    endproperty
    a_rx_follow: assert property (p_rx_follow) else $error("Receiver output did not follow line");

    property p_down_outputs;
        @(posedge CLK) disable iff (!RESET_N)
        (READY || DRV_OE != '0) |-> READY && DRV_OE == '1 && PUMP_EN && $past(clean.pump_reg);
    endproperty
    a_down_outputs: assert property (p_down_outputs) else $error("Drivers on without pump");

    property p_shutdown;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && !clean.shutdown_n) |=> state == SLPM_ST_DOWN && !PUMP_EN && !READY;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("Shutdown did not power down");

    property p_timer_restart;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && activity) |=> idle == '0;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("Edge did not restart timer");

    property p_bit_spacing;
        @(posedge CLK) disable iff (!RESET_N)
        (CE && pop) |=> !pop [*8];
    endproperty
    a_bit_spacing: assert property (p_bit_spacing) else $error("Driver words too close");
endmodule // slpm_manager

// [dv/slpm_line_model.sv]
/*
 * Model of the far side: serial cable levels seen by both receivers, and the
 * analog charge pump that reports regulation some cycles after it is enabled.
 * Assumes the bench selects the line condition with a small command code.
 */
`timescale 1ns/1ps

module slpm_line_model
    import slpm_pkg::*;
#(
    parameter int PUMP_DELAY = 20
)
(
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     pump_en,
    input  wire logic [1:0]               line_cmd,
    output logic                          pump_regulated,
    output logic      [SLPM_CHANNELS-1:0] rx_line_in,
    output logic      [SLPM_CHANNELS-1:0] rx_line_valid,
    output logic      [SLPM_CHANNELS-1:0] rx_line_quiet
);
    // ------------------------------------------------------------
    // Line and pump
    // ------------------------------------------------------------
    int pump_cnt;

    // Channels carry opposite polarities so a swapped bit shows up.
    // Quiet lines read as negative: the receiver input pulls to ground.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pump_cnt       <= 0;
            pump_regulated <= 1'b0;
            rx_line_in     <= 2'b00;
            rx_line_valid  <= 2'b00;
            rx_line_quiet  <= 2'b11;
        end
        else
        begin
            // The rail collapses at once when the pump stops
            pump_cnt       <= pump_en ? ((pump_cnt < PUMP_DELAY) ? pump_cnt + 1 : pump_cnt) : 0;
            pump_regulated <= pump_en && (pump_cnt >= PUMP_DELAY);
            case (line_cmd)
                2'h1:    rx_line_in <= 2'b01;
                2'h2:    rx_line_in <= 2'b10;
                default: rx_line_in <= 2'b00;
            endcase
            rx_line_valid <= (line_cmd == 2'h0) ? 2'b00 : 2'b11;
            rx_line_quiet <= (line_cmd == 2'h0) ? 2'b11 : 2'b00;
        end
    end
endmodule // slpm_line_model

// [dv/test_slpm_manager.sv]
/*
 * Self-checking bench of the serial line power manager: host stream, force
 * pins, inactivity timer and signal detector, with the line model beside it.
 * Assumes a shortened inactivity count; the timer expectations derive from it.
 */
`timescale 1ns/1ps

module test_slpm_manager
    import slpm_pkg::*;
;
    localparam int INACT = 200;

    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    logic       keep_r = 1'b1;
    logic       shut_r = 1'b0;
    logic       tie = 1'b0;
    logic       tx_valid = 1'b0;
    logic [1:0] tx_data = 2'b00;
    logic [1:0] line_cmd = 2'h0;
    logic       keep_awake, shutdown_n, pump_reg, tx_ready, pump_en, ready, sig_absent_n;
    logic [1:0] rx_lvl, rx_valid, rx_quiet, drv_out, drv_oe, rx_out, prev;
    int         errors = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         last;

    // Host wiring of the force pins; tie selects the detector-driven mode
    assign keep_awake = tie ? sig_absent_n : keep_r;
    assign shutdown_n = tie ? sig_absent_n : shut_r;

    always #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    slpm_manager #(.INACT_CYCLES(SLPM_IDLE_W'(INACT))) u_slpm_manager (
        .CLK(clk), .RESET_N(reset_n), .CE(1'b1), .KEEP_AWAKE_IN(keep_awake),
        .SHUTDOWN_N_IN(shutdown_n), .PUMP_REGULATED(pump_reg), .RX_LINE_IN(rx_lvl),
        .RX_LINE_VALID(rx_valid), .RX_LINE_QUIET(rx_quiet), .TX_VALID(tx_valid),
        .TX_READY(tx_ready), .TX_DATA(tx_data), .PUMP_EN(pump_en), .READY(ready),
        .DRV_OUT(drv_out), .DRV_OE(drv_oe), .RX_LOGIC_OUT(rx_out), .SIG_ABSENT_N(sig_absent_n));

    slpm_line_model u_slpm_line_model (
        .clk(clk), .reset_n(reset_n), .pump_en(pump_en), .line_cmd(line_cmd),
        .pump_regulated(pump_reg), .rx_line_in(rx_lvl), .rx_line_valid(rx_valid),
        .rx_line_quiet(rx_quiet));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Waits for READY (sel 0) or SIG_ABSENT_N (sel 1) to reach val
    task automatic wait_for(input string name, input int sel, input logic val, input int bound);
        int n;
        n = 0;
        while (((sel == 0) ? ready : sig_absent_n) !== val && n < bound)
        begin
            @(negedge clk);
            n++;
        end
        check(name, (sel == 0) ? ready : sig_absent_n, val);
        // A timed-out wait has already counted its mismatch above
        if (((sel == 0) ? ready : sig_absent_n) !== val)
            end_of_test();
    endtask

    // One host word; TX_READY sampled mid-cycle decides the next edge's take
    task automatic push(input logic [1:0] w, input logic accept);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data  <= w;
        @(negedge clk);
        check("tx_ready", tx_ready, accept);
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask

    task automatic set_line(input logic [1:0] c);
        @(posedge clk);
        line_cmd <= c;
        idle(10);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        idle(2);
        check("ready_rst", ready, 1'b0);
        check("oe_rst", drv_oe, 2'b00);
        check("drv_rst", drv_out, SLPM_DRV_OUT_RST);
        check("rx_rst", rx_out, SLPM_RX_OUT_RST);
        check("abs_rst", sig_absent_n, SLPM_ABSENT_N_RST);
        check("pump_rst", pump_en, 1'b0);

        // Manual power down wins over keep-awake; receivers stay alive
        set_line(2'h1);
        for (int k = 0; k < SLPM_FIFO_DEPTH; k++)
            push(k[0] ? 2'b10 : 2'b01, 1'b1);
        push(2'b11, 1'b0); // FIFO full refuses
        idle(20);
        check("ready_off", ready, 1'b0);
        check("oe_off", drv_oe, 2'b00);
        check("pump_off", pump_en, 1'b0);
        check("rx_pos", rx_out, 2'b10);
        check("abs_valid", sig_absent_n, 1'b1);
        set_line(2'h2);
        check("rx_neg", rx_out, 2'b01);
        set_line(2'h0);
        idle(SLPM_ABSENT_CYCLES - 15);
        check("abs_dwell", sig_absent_n, 1'b1);
        wait_for("abs_quiet", 1, 1'b0, 40);

        // Forced on: pump, ready, then the stored words at line rate
        @(posedge clk);
        shut_r <= 1'b1;
        wait_for("ready_on", 0, 1'b1, 100);
        check("oe_on", drv_oe, 2'b11);
        check("pump_on", pump_en, 1'b1);
        prev = 2'b11;
        last = cyc;
        for (int k = 0; k < SLPM_FIFO_DEPTH; k++)
        begin
            for (int n = 0; n < 300 && drv_out === prev; n++)
                @(negedge clk);
            check("drv_word", drv_out, k[0] ? 2'b01 : 2'b10);
            if (drv_out === prev)
                end_of_test();
            if (k > 0)
                check("bit_gap", (cyc - last) >= SLPM_BIT_CYCLES, 1'b1);
            last = cyc;
            prev = drv_out;
        end
        check("tx_ready_drained", tx_ready, 1'b1);
        idle(INACT + 100);
        check("ready_forced", ready, 1'b1);

        // Automatic mode: time out, wake on an edge, edges restart the timer
        @(posedge clk);
        keep_r <= 1'b0;
        wait_for("ready_timeout", 0, 1'b0, INACT + 100);
        check("oe_timeout", drv_oe, 2'b00);
        set_line(2'h1);
        wait_for("ready_wake", 0, 1'b1, 100);
        idle(100);
        check("ready_recent", ready, 1'b1);
        set_line(2'h2);
        idle(140);
        check("ready_restart", ready, 1'b1);
        wait_for("ready_timeout2", 0, 1'b0, 300);
        check("oe_timeout2", drv_oe, 2'b00);

        // Force pins following the detector output
        @(posedge clk);
        tie <= 1'b1;
        set_line(2'h1);
        wait_for("ready_tied", 0, 1'b1, 100);
        set_line(2'h0);
        wait_for("ready_tied_off", 0, 1'b0, SLPM_ABSENT_CYCLES + 100);
        check("oe_tied_off", drv_oe, 2'b00);
        check("abs_tied_off", sig_absent_n, 1'b0);
        end_of_test();
    end
endmodule // test_slpm_manager
